// [pkg/rxfe_pkg.sv]
// Package for the receive front-end level monitor.
// Holds the register map, field positions, reset values and widths.
// Assumes an 8-bit host port with 8-bit register offsets.
package rxfe_pkg;

  // Register offsets on the host port.
  localparam logic [7:0] OFS_INTR_MASK_UPPER = 8'h03;
  localparam logic [7:0] OFS_INTR_CAUSE = 8'h05;
  localparam logic [7:0] OFS_INTERVAL_LEN_LO = 8'h18;
  localparam logic [7:0] OFS_INTERVAL_LEN_HI = 8'h19;
  localparam logic [7:0] OFS_CONVERTER_CTRL = 8'h21;
  localparam logic [7:0] OFS_BIAS_CORR_LO = 8'h26;
  localparam logic [7:0] OFS_BIAS_CORR_HI = 8'h27;
  localparam logic [7:0] OFS_REMOTE_UPPER_LIMIT_LO = 8'h30;
  localparam logic [7:0] OFS_REMOTE_UPPER_LIMIT_HI = 8'h31;
  localparam logic [7:0] OFS_REMOTE_LOWER_LIMIT_LO = 8'h32;
  localparam logic [7:0] OFS_REMOTE_LOWER_LIMIT_HI = 8'h33;
  localparam logic [7:0] OFS_CLIP_COUNT = 8'h42;
  localparam logic [7:0] OFS_BIAS_LEVEL_LO = 8'h44;
  localparam logic [7:0] OFS_BIAS_LEVEL_HI = 8'h45;
  localparam logic [7:0] OFS_MAGNITUDE_LEVEL_LO = 8'h46;
  localparam logic [7:0] OFS_MAGNITUDE_LEVEL_HI = 8'h47;
  localparam logic [7:0] OFS_REMOTE_LEVEL_LO = 8'h48;
  localparam logic [7:0] OFS_REMOTE_LEVEL_HI = 8'h49;

  // Alarm bit positions, shared by the cause and upper mask registers.
  localparam int BIT_ALARM_HIGH = 2;
  localparam int BIT_ALARM_LOW = 1;

  // Gain field of the converter control register and its top code.
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  localparam logic [2:0] GAIN_MAX = 3'h5;

  // Widths of samples, results, accumulators and the clip counter.
  localparam int SMP_W = 16;
  localparam int RES_W = 16;
  localparam int ACC_W = 32;
  localparam int CLIP_W = 8;
  localparam logic [7:0] CLIP_MAX = 8'hff;

  // Reset values of the writable registers.
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [15:0] RST_INTERVAL = 16'hffff;
  localparam logic [7:0] RST_CONV_CTRL = 8'h00;
  localparam logic [15:0] RST_BIAS = 16'h0000;
  localparam logic [15:0] RST_UPPER_LIMIT = 16'h7fff;
  localparam logic [15:0] RST_LOWER_LIMIT = 16'h8000;

endpackage : rxfe_pkg

// [pkg/rxfe_meter_if.sv]
// Interface that carries the meter step and interval close strobes.
// Assumes both strobes are already gated by the clock enable.
`timescale 1ns/100ps
`default_nettype none
interface rxfe_meter_if;
  logic step;  // One sample is presented this cycle.
  logic close; // This sample is the last of the meter interval.
  modport ctrl (output step, output close);
  modport mtr (input step, input close);
endinterface : rxfe_meter_if
`default_nettype wire

// [core/rxfe_accum.sv]
// Signed accumulator with latched 16-bit result for one level meter.
// Assumes step and close come from the meter timer on the same clock.
`timescale 1ns/100ps
`default_nettype none
module rxfe_accum (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Meter strobes.
  rxfe_meter_if.mtr meter,
  // Sample in and result out.
  input wire logic signed [rxfe_pkg::SMP_W:0] value,
  output logic [rxfe_pkg::RES_W-1:0] result_ff
);

  logic signed [rxfe_pkg::ACC_W-1:0] acc_ff; // Running sum.
  logic signed [rxfe_pkg::ACC_W-1:0] nxt_acc; // Sum with this sample.

  // Sign-extend the sample into the running sum.
  always_comb begin
    nxt_acc = acc_ff + rxfe_pkg::ACC_W'(value);
  end

  // Sum each step; at close keep the top bits and restart from zero.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff <= '0;
      result_ff <= '0;
    end else if (meter.step) begin
      if (meter.close) begin
        result_ff <= nxt_acc[rxfe_pkg::ACC_W-1 -: rxfe_pkg::RES_W];
        acc_ff <= '0;
      end else begin
        acc_ff <= nxt_acc;
      end
    end
  end

endmodule : rxfe_accum
`default_nettype wire

// [core/rxfe_clip_ctr.sv]
// Saturating converter overflow counter with an interval result.
// Assumes the overflow flag arrives with its sample on the same clock.
`timescale 1ns/100ps
`default_nettype none
module rxfe_clip_ctr (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Meter strobes.
  rxfe_meter_if.mtr meter,
  // Overflow flag in and count out.
  input wire logic ovf,
  output logic [rxfe_pkg::CLIP_W-1:0] count_ff
);

  logic [rxfe_pkg::CLIP_W-1:0] cnt_ff; // Count in this interval.
  logic [rxfe_pkg::CLIP_W-1:0] nxt_cnt; // Count including this sample.

  // Add one per overflow but hold at the top value.
  always_comb begin
    nxt_cnt = cnt_ff;
    if (ovf && (cnt_ff != rxfe_pkg::CLIP_MAX)) begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  // Count, then hand the total over and restart at the close.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      count_ff <= '0;
    end else if (meter.step) begin
      if (meter.close) begin
        count_ff <= nxt_cnt;
        cnt_ff <= '0;
      end else begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

endmodule : rxfe_clip_ctr
`default_nettype wire

// [core/rxfe_top.sv]
// Receive digital front end: offset removal, level meters, overflow
// counter, far-end alarms and the receive gain select.
// Assumes converter and echo-canceller samples are made on sys_clk,
// one per symbol, so they need no synchroniser.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Subtract host 16-bit offset from each converter sample.
// - Top 16 bits of offset-corrected sum stored.
// - Top 16 bits of absolute sum stored.
// - Count each converter overflow in interval.
// - Overflow counter 8 bits, holds at 255.
// - Overflow count latched at interval end.
// - Top 16 bits of far-end sum stored.
// - Far-end result versus thresholds raises interrupt.
// - High alarm bit 2, low bit 1.
// - Mask bit one suppresses that alarm interrupt.
// - Six gain settings from 3-bit field.
// - One 16-bit converter sample per symbol.
// - All processing at one sample per symbol.
module rxfe_top (
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Converter sample stream.
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  input wire logic adc_ovf,
  // Echo-cancelled far-end sample, valid with adc_valid.
  input wire logic [15:0] fe_data,
  // Host port.
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata_ff,
  output logic irq_b,
  // Corrected sample for the later receive stages.
  output logic [15:0] rx_sample_ff,
  output logic rx_valid_ff,
  // Gain select for the amplifier before the converter.
  output logic [2:0] vga_gain_ff
);

  // Writable register state.
  logic [7:0] mask_ff; // Upper interrupt mask.
  logic [15:0] interval_ff; // Meter interval in samples.
  logic [7:0] conv_ctrl_ff; // Converter control.
  logic [15:0] bias_ff; // Offset subtracted from samples.
  logic [15:0] upper_lim_ff; // High alarm threshold, signed.
  logic [15:0] lower_lim_ff; // Low alarm threshold, signed.

  // Status state.
  logic [7:0] cause_ff; // Sticky alarm causes.
  logic [15:0] tick_ff; // Samples seen in this interval.
  logic close_d_ff; // Results were latched last cycle.

  // Meter results from the submodules.
  logic [15:0] dc_res;
  logic [15:0] mag_res;
  logic [15:0] fe_res;
  logic [7:0] clip_res;

  // Datapath signals.
  logic step; // A sample is taken this cycle.
  logic close; // Interval ends with this sample.
  logic signed [16:0] corr_wide; // Raw difference.
  logic signed [16:0] corr; // Saturated corrected sample.
  logic [16:0] corr_abs; // Magnitude of the corrected sample.
  logic alarm_hi; // High threshold crossed.
  logic alarm_lo; // Low threshold crossed.
  logic [7:0] nxt_cause;
  logic [7:0] nxt_rdata;

  rxfe_meter_if meter ();

  // Clamp a 17-bit difference back into the 16-bit signed range.
  // Saturating rather than wrapping keeps a large offset from
  // flipping the sign of a sample the meters then see.
  function automatic logic signed [16:0] sat16(
    input logic signed [16:0] v
  );
    logic signed [16:0] r;
    r = v;
    if (v > 17'sh07fff) begin
      r = 17'sh07fff;
    end else if (v < -17'sh08000) begin
      r = -17'sh08000;
    end
    return r;
  endfunction : sat16

  // Pick the low or high byte of one word for the read mux.
  function automatic logic [7:0] pick(
    input logic [15:0] w,
    input logic hi
  );
    return hi ? w[15:8] : w[7:0];
  endfunction : pick

  // A sample per symbol, frozen while the clock enable is low.
  assign step = clk_en && adc_valid;

  // Close on the sample that completes the programmed count; a
  // count of zero or one closes every sample.
  assign close = step &&
    (({1'b0, tick_ff} + 17'h00001) >= {1'b0, interval_ff});

  assign meter.step = step;
  assign meter.close = close;

  // Offset removal ahead of the DC and magnitude meters.
  always_comb begin
    corr_wide = $signed({adc_data[15], adc_data}) -
      $signed({bias_ff[15], bias_ff});
    corr = sat16(corr_wide);
    if (corr[16]) begin
      corr_abs = 17'(-corr);
    end else begin
      corr_abs = corr;
    end
  end

  // Meter interval counter; restarts after each close.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= '0;
    end else if (step) begin
      if (close) begin
        tick_ff <= '0;
      end else begin
        tick_ff <= tick_ff + 16'h0001;
      end
    end
  end

  // DC level meter on the corrected sample.
  rxfe_accum u_dc (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .meter(meter),
    .value(corr),
    .result_ff(dc_res)
  );

  // Signal level meter on the magnitude.
  rxfe_accum u_mag (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .meter(meter),
    .value($signed(corr_abs)),
    .result_ff(mag_res)
  );

  // Far-end level meter on the echo-cancelled signal.
  rxfe_accum u_fe (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .meter(meter),
    .value($signed({fe_data[15], fe_data})),
    .result_ff(fe_res)
  );

  // Overflow counter, saturating, handed over at each close.
  rxfe_clip_ctr u_clip (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .meter(meter),
    .ovf(adc_ovf),
    .count_ff(clip_res)
  );

  // Pass the corrected sample on to the later receive stages.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sample_ff <= '0;
      rx_valid_ff <= 1'b0;
    end else if (clk_en) begin
      rx_valid_ff <= adc_valid;
      if (adc_valid) begin
        rx_sample_ff <= corr[15:0];
      end
    end
  end

  // Remember that new results stand, so alarms look at them once.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      close_d_ff <= 1'b0;
    end else if (clk_en) begin
      close_d_ff <= close;
    end
  end

  // Threshold checks on the freshly latched far-end result.
  // Thresholds and result are compared as signed numbers.
  assign alarm_hi = close_d_ff &&
    ($signed(fe_res) > $signed(upper_lim_ff));
  assign alarm_lo = close_d_ff &&
    ($signed(fe_res) < $signed(lower_lim_ff));

  // Cause bits are sticky and clear when the cause register is read.
  // A new alarm in the reading cycle survives, since set wins.
  always_comb begin
    nxt_cause = cause_ff;
    if (host_rd && (host_addr == rxfe_pkg::OFS_INTR_CAUSE)) begin
      nxt_cause = 8'h00;
    end
    if (alarm_hi) begin
      nxt_cause[rxfe_pkg::BIT_ALARM_HIGH] = 1'b1;
    end
    if (alarm_lo) begin
      nxt_cause[rxfe_pkg::BIT_ALARM_LOW] = 1'b1;
    end
  end

  // Hold the cause register.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_ff <= '0;
    end else if (clk_en) begin
      cause_ff <= nxt_cause;
    end
  end

  // One active-low interrupt; a mask bit of one blocks its cause.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b <= 1'b1;
    end else if (clk_en) begin
      irq_b <= ~|(nxt_cause & ~mask_ff);
    end
  end

  // Host writes to the control registers; read-only ones ignore it.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_ff <= rxfe_pkg::RST_MASK;
      interval_ff <= rxfe_pkg::RST_INTERVAL;
      conv_ctrl_ff <= rxfe_pkg::RST_CONV_CTRL;
      bias_ff <= rxfe_pkg::RST_BIAS;
      upper_lim_ff <= rxfe_pkg::RST_UPPER_LIMIT;
      lower_lim_ff <= rxfe_pkg::RST_LOWER_LIMIT;
    end else if (clk_en && host_wr) begin
      case (host_addr)
        rxfe_pkg::OFS_INTR_MASK_UPPER: begin
          mask_ff <= host_wdata;
        end
        rxfe_pkg::OFS_INTERVAL_LEN_LO: begin
          interval_ff[7:0] <= host_wdata;
        end
        rxfe_pkg::OFS_INTERVAL_LEN_HI: begin
          interval_ff[15:8] <= host_wdata;
        end
        rxfe_pkg::OFS_CONVERTER_CTRL: begin
          conv_ctrl_ff <= host_wdata;
        end
        rxfe_pkg::OFS_BIAS_CORR_LO: begin
          bias_ff[7:0] <= host_wdata;
        end
        rxfe_pkg::OFS_BIAS_CORR_HI: begin
          bias_ff[15:8] <= host_wdata;
        end
        rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_LO: begin
          upper_lim_ff[7:0] <= host_wdata;
        end
        rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_HI: begin
          upper_lim_ff[15:8] <= host_wdata;
        end
        rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_LO: begin
          lower_lim_ff[7:0] <= host_wdata;
        end
        rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_HI: begin
          lower_lim_ff[15:8] <= host_wdata;
        end
        default: begin
          // Read-only or unmapped: the write has no effect.
        end
      endcase
    end
  end

  // Gain select; the two spare codes fall back to the top setting so
  // the amplifier never sees an undefined code.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      vga_gain_ff <= '0;
    end else if (clk_en) begin
      if (conv_ctrl_ff[rxfe_pkg::GAIN_LSB +: rxfe_pkg::GAIN_W] >
          rxfe_pkg::GAIN_MAX) begin
        vga_gain_ff <= rxfe_pkg::GAIN_MAX;
      end else begin
        vga_gain_ff <=
          conv_ctrl_ff[rxfe_pkg::GAIN_LSB +: rxfe_pkg::GAIN_W];
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    case (host_addr)
      rxfe_pkg::OFS_INTR_MASK_UPPER: nxt_rdata = mask_ff;
      rxfe_pkg::OFS_INTR_CAUSE: nxt_rdata = cause_ff;
      rxfe_pkg::OFS_INTERVAL_LEN_LO: nxt_rdata = pick(interval_ff, 1'b0);
      rxfe_pkg::OFS_INTERVAL_LEN_HI: nxt_rdata = pick(interval_ff, 1'b1);
      rxfe_pkg::OFS_CONVERTER_CTRL: nxt_rdata = conv_ctrl_ff;
      rxfe_pkg::OFS_BIAS_CORR_LO: nxt_rdata = pick(bias_ff, 1'b0);
      rxfe_pkg::OFS_BIAS_CORR_HI: nxt_rdata = pick(bias_ff, 1'b1);
      rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_LO: begin
        nxt_rdata = pick(upper_lim_ff, 1'b0);
      end
      rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_HI: begin
        nxt_rdata = pick(upper_lim_ff, 1'b1);
      end
      rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_LO: begin
        nxt_rdata = pick(lower_lim_ff, 1'b0);
      end
      rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_HI: begin
        nxt_rdata = pick(lower_lim_ff, 1'b1);
      end
      rxfe_pkg::OFS_CLIP_COUNT: nxt_rdata = clip_res;
      rxfe_pkg::OFS_BIAS_LEVEL_LO: nxt_rdata = pick(dc_res, 1'b0);
      rxfe_pkg::OFS_BIAS_LEVEL_HI: nxt_rdata = pick(dc_res, 1'b1);
      rxfe_pkg::OFS_MAGNITUDE_LEVEL_LO: begin
        nxt_rdata = pick(mag_res, 1'b0);
      end
      rxfe_pkg::OFS_MAGNITUDE_LEVEL_HI: begin
        nxt_rdata = pick(mag_res, 1'b1);
      end
      rxfe_pkg::OFS_REMOTE_LEVEL_LO: nxt_rdata = pick(fe_res, 1'b0);
      rxfe_pkg::OFS_REMOTE_LEVEL_HI: nxt_rdata = pick(fe_res, 1'b1);
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data is registered and stands until the next read.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_ff <= '0;
    end else if (clk_en && host_rd) begin
      host_rdata_ff <= nxt_rdata;
    end
  end

endmodule : rxfe_top
`default_nettype wire

// [verification/rxfe_top_asserts.sv]
// Port checker for the receive front-end level monitor.
// Bound to rxfe_top; sees only its ports, on the one symbol clock.
`timescale 1ns/100ps
`default_nettype none
module rxfe_top_asserts (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Inputs watched.
  input wire logic clk_en,
  input wire logic adc_valid,
  input wire logic [15:0] adc_data,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  // Outputs checked.
  input wire logic [7:0] host_rdata_ff,
  input wire logic irq_b,
  input wire logic [15:0] rx_sample_ff,
  input wire logic rx_valid_ff,
  input wire logic [2:0] vga_gain_ff
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] mask_ff; // Copy of the upper mask register.
  logic [15:0] bias_ff; // Copy of the offset register pair.
  logic wr_en; // A write is taken this cycle.
  logic ctl_wr; // A write to the converter control register.
  logic signed [16:0] dif; // Raw offset-corrected sample.
  logic [15:0] want; // Corrected sample after saturation.
  assign wr_en = clk_en & host_wr;
  assign ctl_wr = wr_en && host_addr == rxfe_pkg::OFS_CONVERTER_CTRL;
  assign dif = $signed({adc_data[15], adc_data})
    - $signed({bias_ff[15], bias_ff});
  // Saturation instead of wrap keeps a clipped sample on the right side.
  assign want = (dif[16] != dif[15]) ? {dif[16], {15{~dif[16]}}}
    : dif[15:0];
  // The mask copy follows host writes.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) mask_ff <= 8'h00;
    else if (wr_en && host_addr == rxfe_pkg::OFS_INTR_MASK_UPPER)
      mask_ff <= host_wdata;
  end
  // The offset copy keeps its halves apart, as the design does.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) bias_ff <= 16'h0000;
    else if (wr_en && host_addr == rxfe_pkg::OFS_BIAS_CORR_LO)
      bias_ff[7:0] <= host_wdata;
    else if (wr_en && host_addr == rxfe_pkg::OFS_BIAS_CORR_HI)
      bias_ff[15:8] <= host_wdata;
  end
  offset_sub_a: assert property (
    clk_en && adc_valid |=> rx_sample_ff == $past(want))
    else $error("corrected sample wrong");
  sample_follow_a: assert property (
    clk_en && adc_valid |=> rx_valid_ff)
    else $error("sample strobe not passed on");
  sample_idle_a: assert property (
    clk_en && !adc_valid |=> !rx_valid_ff && $stable(rx_sample_ff))
    else $error("output moved without a sample");
  // The gain output follows the control register one cycle late.
  gain_map_a: assert property (
    ctl_wr |-> ##2 vga_gain_ff == (($past(host_wdata[2:0], 2) > 3'h5) ?
      rxfe_pkg::GAIN_MAX : $past(host_wdata[2:0], 2)))
    else $error("gain code wrong");
  gain_range_a: assert property (
    vga_gain_ff <= rxfe_pkg::GAIN_MAX)
    else $error("gain code out of range");
  gain_hold_a: assert property (
    !ctl_wr && !$past(ctl_wr) |=> $stable(vga_gain_ff))
    else $error("gain changed without a write");
  alarm_mask_a: assert property (
    irq_b && mask_ff[2:1] == 2'b11 && !wr_en |=> irq_b)
    else $error("masked alarm raised interrupt");
  cause_bits_a: assert property (
    clk_en && host_rd && host_addr == rxfe_pkg::OFS_INTR_CAUSE
      |=> host_rdata_ff[7:3] == 5'h00 && !host_rdata_ff[0])
    else $error("cause read shows unused bits");
endmodule : rxfe_top_asserts
`default_nettype wire

// [verification/rxfe_src_model.sv]
// Converter and echo-canceller sample source facing the front end.
// Drives on the falling edge; released lines show the inverse value.
`timescale 1ns/100ps
`default_nettype none
module rxfe_src_model (
  // Symbol clock.
  input wire logic sys_clk,
  // Sample stream.
  output logic adc_valid,
  output logic [15:0] adc_data,
  output logic adc_ovf,
  output logic [15:0] fe_data
);
  // Idle lines at time zero.
  initial begin
    adc_valid = 1'b0;
    adc_data = 16'h5a5a;
    adc_ovf = 1'b0;
    fe_data = 16'ha5a5;
  end
  // Sends n back-to-back samples, one per symbol clock.
  task automatic burst(input int n, input logic [15:0] d,
    input logic [15:0] f, input logic o);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      adc_valid = 1'b1;
      adc_data = d;
      fe_data = f;
      adc_ovf = o;
    end
    @(negedge sys_clk);
    // Flipped lines keep a stale value from passing for a sample.
    adc_valid = 1'b0;
    adc_data = ~d;
    fe_data = ~f;
    adc_ovf = ~o;
  endtask : burst
endmodule : rxfe_src_model
`default_nettype wire

// [verification/rx_front_end_level_monitor_bench.sv]
// Self-checking bench for the receive front-end level monitor.
// Assumes the source model and the port checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module rx_front_end_level_monitor_bench;
  logic sys_clk = 1'b0; // Symbol clock.
  logic rst_b = 1'b0; // Reset, held low at start.
  logic [7:0] host_addr = 8'h00; // Host port drive.
  logic [7:0] host_wdata = 8'h00;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic clk_en = 1'b1; // Clock enable, dropped once to test freezing.
  logic adc_valid, adc_ovf, irq_b, rx_valid_ff;
  logic [15:0] adc_data, fe_data, rx_sample_ff;
  logic [7:0] host_rdata_ff;
  logic [2:0] vga_gain_ff;
  int fail_count = 0;
  int cmp_count = 0;
  // 25 MHz clock.
  always #20 sys_clk = ~sys_clk;
  rxfe_src_model src (.sys_clk(sys_clk), .adc_valid(adc_valid),
    .adc_data(adc_data), .adc_ovf(adc_ovf), .fe_data(fe_data));
  // The clock enable is driven so that a frozen write can be tried.
  rxfe_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .adc_valid(adc_valid), .adc_data(adc_data), .adc_ovf(adc_ovf),
    .fe_data(fe_data), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_wr(host_wr), .host_rd(host_rd), .host_rdata_ff(host_rdata_ff),
    .irq_b(irq_b), .rx_sample_ff(rx_sample_ff),
    .rx_valid_ff(rx_valid_ff), .vga_gain_ff(vga_gain_ff));
  // Counts a compare and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One host write, strobe high for one cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge sys_clk);
    host_wr = 1'b0;
  endtask : wr
  // One host read; data is settled by the next falling edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge sys_clk);
    host_rd = 1'b0;
    chk({8'h00, host_rdata_ff}, {8'h00, e});
  endtask : rd
  // Reads a result pair, low byte first.
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 8'h01, e[15:8]);
  endtask : rd16
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic fin(input string n);
    $display("test %s done", n);
  endtask : fin
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // A hang would otherwise stop the run silently.
  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    rd(rxfe_pkg::OFS_INTR_MASK_UPPER, 8'h00);
    rd(rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_HI, 8'h7f);
    rd(rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_HI, 8'h80);
    rd(rxfe_pkg::OFS_INTR_CAUSE, 8'h00);
    rd(8'hff, 8'h00);
    fin("reset");
    for (int c = 0; c < 8; c++) begin
      wr(rxfe_pkg::OFS_CONVERTER_CTRL, 8'(c));
      // The gain output follows the control register one cycle late.
      idle(1);
      chk({13'h0, vga_gain_ff}, (c > 5) ? 16'h0005 : 16'(c));
    end
    fin("gain");
    // Two full-scale negative samples give a low far-end alarm.
    wr(rxfe_pkg::OFS_INTERVAL_LEN_LO, 8'h02);
    wr(rxfe_pkg::OFS_INTERVAL_LEN_HI, 8'h00);
    wr(rxfe_pkg::OFS_BIAS_CORR_LO, 8'h10);
    wr(rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_LO, 8'h00);
    wr(rxfe_pkg::OFS_REMOTE_LOWER_LIMIT_HI, 8'h00);
    src.burst(2, 16'h8010, 16'h8000, 1'b1);
    chk(rx_sample_ff, 16'h8000);
    idle(2);
    chk({15'h0, irq_b}, 16'h0000);
    rd(rxfe_pkg::OFS_INTR_CAUSE, 8'h02);
    rd16(rxfe_pkg::OFS_BIAS_LEVEL_LO, 16'hffff);
    rd16(rxfe_pkg::OFS_MAGNITUDE_LEVEL_LO, 16'h0001);
    rd16(rxfe_pkg::OFS_REMOTE_LEVEL_LO, 16'hffff);
    rd(rxfe_pkg::OFS_CLIP_COUNT, 8'h02);
    chk({15'h0, irq_b}, 16'h0001);
    fin("meters");
    // A fresh interval of zero corrected samples must not carry old sums.
    wr(rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_LO, 8'hff);
    wr(rxfe_pkg::OFS_REMOTE_UPPER_LIMIT_HI, 8'hff);
    src.burst(2, 16'h0010, 16'h7fff, 1'b0);
    idle(2);
    rd(rxfe_pkg::OFS_INTR_CAUSE, 8'h04);
    rd16(rxfe_pkg::OFS_BIAS_LEVEL_LO, 16'h0000);
    rd16(rxfe_pkg::OFS_MAGNITUDE_LEVEL_LO, 16'h0000);
    rd16(rxfe_pkg::OFS_REMOTE_LEVEL_LO, 16'h0000);
    rd(rxfe_pkg::OFS_CLIP_COUNT, 8'h00);
    fin("high alarm");
    wr(rxfe_pkg::OFS_INTR_MASK_UPPER, 8'h06);
    rd(rxfe_pkg::OFS_INTR_MASK_UPPER, 8'h06);
    src.burst(2, 16'h0010, 16'h7fff, 1'b0);
    idle(2);
    chk({15'h0, irq_b}, 16'h0001);
    fin("mask");
    // 256 overflows in one interval; the sample also saturates.
    wr(rxfe_pkg::OFS_INTERVAL_LEN_LO, 8'h00);
    wr(rxfe_pkg::OFS_INTERVAL_LEN_HI, 8'h01);
    src.burst(256, 16'h8000, 16'h0000, 1'b1);
    chk(rx_sample_ff, 16'h8000);
    rd(rxfe_pkg::OFS_CLIP_COUNT, 8'hff);
    rd16(rxfe_pkg::OFS_BIAS_LEVEL_LO, 16'hff80);
    rd16(rxfe_pkg::OFS_MAGNITUDE_LEVEL_LO, 16'h0080);
    fin("overflow");
    // Unmasking only the high alarm lets its pending cause through.
    wr(rxfe_pkg::OFS_INTR_MASK_UPPER, 8'h02);
    idle(1);
    chk({15'h0, irq_b}, 16'h0000);
    // A write while the clock enable is low must be ignored.
    clk_en = 1'b0;
    wr(rxfe_pkg::OFS_INTR_MASK_UPPER, 8'hff);
    clk_en = 1'b1;
    rd(rxfe_pkg::OFS_INTR_MASK_UPPER, 8'h02);
    rd(rxfe_pkg::OFS_INTR_CAUSE, 8'h04);
    fin("mask bits and freeze");
    report_and_stop();
  end
endmodule : rx_front_end_level_monitor_bench
bind rxfe_top rxfe_top_asserts chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .clk_en(clk_en), .adc_valid(adc_valid), .adc_data(adc_data),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
  .host_rd(host_rd), .host_rdata_ff(host_rdata_ff), .irq_b(irq_b),
  .rx_sample_ff(rx_sample_ff), .rx_valid_ff(rx_valid_ff),
  .vga_gain_ff(vga_gain_ff));
`default_nettype wire
